// file: design/led_pwm_intensity.sv
`include "led_pwm_defs.svh"

module led_pwm_intensity #(
	parameter int N_OUTPUTS = `NUM_OUTPUTS
) (
	input  wire logic                          i_clk,             // core oscillator clock
	input  wire logic                          i_rst,             // sync reset, active high
	input  wire logic                          i_reg_strobe,      // register transfer request
	input  wire logic                          i_reg_rnw,         // direction: 1 read, 0 write
	input  wire led_pwm_pkg::byte_type         i_reg_addr,        // register address
	input  wire led_pwm_pkg::byte_type         i_reg_wdata,       // write data
	output led_pwm_pkg::byte_type              o_reg_rdata,       // read data
	output logic                               o_reg_rvalid,      // read data valid pulse
	input  wire logic                          i_blink_en,        // blinking enabled
	input  wire logic                          i_blink_phase,     // active blink phase
	input  wire logic                          i_global_en,       // one code for outputs 0-15
	input  wire led_pwm_pkg::level_type        i_global_code,     // global intensity code
	input  wire led_pwm_pkg::level_type [15:0] i_out_codes,       // per-output codes
	input  wire logic [7:0]                    i_ph0_low_group,   // phase 0 bits, outputs 0-7
	input  wire logic [7:0]                    i_ph0_high_group,  // phase 0 bits, outputs 8-15
	input  wire logic [7:0]                    i_ph1_low_group,   // phase 1 bits, outputs 0-7
	input  wire logic [7:0]                    i_ph1_high_group,  // phase 1 bits, outputs 8-15
	input  wire logic                          i_ph0_seventeenth, // phase 0 bit, last output
	input  wire logic                          i_ph1_seventeenth, // phase 1 bit, last output
	output logic [N_OUTPUTS-1:0]               o_led_o,           // pin level when enabled
	output logic [N_OUTPUTS-1:0]               o_led_oe,          // high: pin pulled low
	output logic                               o_osc_running      // oscillator running
);
	import led_pwm_pkg::*;

	if (N_OUTPUTS != `NUM_OUTPUTS) begin : g_bad_count
		$error("output grouping serves exactly seventeen outputs");
	end

	// ****************************************
	// master and seventeenth intensity register
	// ****************************************
	byte_type  reg_q;
	level_type master_level;
	level_type seventeenth_level;
	logic      wr_hit;
	logic      rd_req;

	assign master_level      = reg_q[`MASTER_FIELD_MSB:`MASTER_FIELD_LSB];
	assign seventeenth_level = reg_q[`LAST_FIELD_MSB:`LAST_FIELD_LSB];
	assign wr_hit = i_reg_strobe && !i_reg_rnw && i_reg_addr == `REG_MASTER_ADDR;
	assign rd_req = i_reg_strobe && i_reg_rnw;

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			reg_q <= `REG_MASTER_RESET;
		end else if (wr_hit) begin
			reg_q <= i_reg_wdata;
		end
	end

	// unmapped reads answer zero so the host never waits
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			o_reg_rdata  <= 8'h00;
			o_reg_rvalid <= 1'b0;
		end else begin
			o_reg_rvalid <= rd_req;
			if (rd_req) begin
				o_reg_rdata <= (i_reg_addr == `REG_MASTER_ADDR) ? reg_q : 8'h00;
			end
		end
	end

	// ****************************************
	// oscillator: 16 slots of 15 master sub-slots
	// ****************************************
	osc_state_type state_q;
	logic [3:0]    slot_q;
	logic [3:0]    sub_q;
	logic          run;
	logic          boundary;

	assign run      = state_q == OSC_RUNNING;
	assign boundary = run && slot_q == `PWM_LAST_SLOT && sub_q == `MASTER_LAST_SUB;

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			state_q <= OSC_STOPPED;
		end else begin
			case (state_q)
				OSC_STOPPED: begin
					if (master_level != `MASTER_OFF) begin
						state_q <= OSC_RUNNING;
					end
				end
				OSC_RUNNING: begin
					if (master_level == `MASTER_OFF) begin
						state_q <= OSC_STOPPED;
					end
				end
				default: begin
					state_q <= OSC_STOPPED;
				end
			endcase
		end
	end

	// a stopped oscillator restarts from slot 0 so the first cycle is whole
	always_ff @(posedge i_clk) begin
		if (i_rst || !run) begin
			sub_q  <= 4'h0;
			slot_q <= 4'h0;
		end else if (sub_q == `MASTER_LAST_SUB) begin
			sub_q  <= 4'h0;
			slot_q <= slot_q + 4'h1;
		end else begin
			sub_q <= sub_q + 4'h1;
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			o_osc_running <= 1'b0;
		end else begin
			o_osc_running <= run;
		end
	end

	// ****************************************
	// per-output code and phase selection
	// ****************************************
	level_type [N_OUTPUTS-1:0] code_sel;
	logic [N_OUTPUTS-1:0]      ph0_sel;
	logic [N_OUTPUTS-1:0]      ph1_sel;
	logic [N_OUTPUTS-1:0]      drive;

	always_comb begin
		for (int i = 0; i < 16; i++) begin
			code_sel[i] = i_global_en ? i_global_code : i_out_codes[i];
		end
		code_sel[16] = seventeenth_level;
		// the seventeenth output has its own bits and cannot track the groups
		ph0_sel = {i_ph0_seventeenth, i_ph0_high_group, i_ph0_low_group};
		ph1_sel = {i_ph1_seventeenth, i_ph1_high_group, i_ph1_low_group};
	end

	pwm_timing_if tm ();

	assign tm.slot        = slot_q;
	assign tm.sub         = sub_q;
	assign tm.master      = master_level;
	assign tm.run         = run;
	assign tm.boundary    = boundary;
	assign tm.blink_en    = i_blink_en;
	assign tm.blink_phase = i_blink_phase;

	for (genvar g = 0; g < N_OUTPUTS; g++) begin : g_slice
		led_slice u_slice (
			.i_clk   (i_clk),
			.i_rst   (i_rst),
			.tm      (tm),
			.i_code  (code_sel[g]),
			.i_ph0   (ph0_sel[g]),
			.i_ph1   (ph1_sel[g]),
			.o_drive (drive[g])
		);
	end

	// open drain: the pin is only ever pulled low, a lit LED
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			o_led_o <= '0;
		end else begin
			o_led_o <= '0;
		end
	end

	assign o_led_oe = drive;

	// ****************************************
	// checks
	// ****************************************
	sequence s_write_hit;
		i_reg_strobe && !i_reg_rnw && i_reg_addr == `REG_MASTER_ADDR;
	endsequence

	sequence s_master_off_held;
		master_level == `MASTER_OFF ##1 master_level == `MASTER_OFF;
	endsequence

	property p_write_stores;
		@(posedge i_clk) disable iff (i_rst)
		s_write_hit |=> reg_q == $past(i_reg_wdata);
	endproperty
	a_write_stores: assert property (p_write_stores) else $error("write not stored");

	property p_read_returns;
		@(posedge i_clk) disable iff (i_rst)
		i_reg_strobe && i_reg_rnw && i_reg_addr == `REG_MASTER_ADDR
			|=> o_reg_rvalid && o_reg_rdata == $past(reg_q);
	endproperty
	a_read_returns: assert property (p_read_returns) else $error("readback differs");

	property p_osc_stopped;
		@(posedge i_clk) disable iff (i_rst)
		s_master_off_held |=> sub_q == 4'h0 && slot_q == 4'h0 && !run;
	endproperty
	a_osc_stopped: assert property (p_osc_stopped) else $error("oscillator not stopped");

	property p_outputs_static;
		@(posedge i_clk) disable iff (i_rst)
		s_master_off_held ##1 master_level == `MASTER_OFF |=> o_led_oe == '0;
	endproperty
	a_outputs_static: assert property (p_outputs_static) else $error("pwm with master off");

	property p_slot_advance;
		@(posedge i_clk) disable iff (i_rst)
		run && master_level != `MASTER_OFF && sub_q == `MASTER_LAST_SUB
			|=> sub_q == 4'h0 && slot_q == $past(slot_q) + 4'h1;
	endproperty
	a_slot_advance: assert property (p_slot_advance) else $error("slot step wrong");
endmodule

// file: design/led_pwm_defs.svh
`ifndef LED_PWM_DEFS_SVH
`define LED_PWM_DEFS_SVH

// ****************************************
// register map
// ****************************************
`define REG_MASTER_ADDR    8'h0e
`define REG_MASTER_RESET   8'h00
`define MASTER_FIELD_MSB   7
`define MASTER_FIELD_LSB   4
`define LAST_FIELD_MSB     3
`define LAST_FIELD_LSB     0

// ****************************************
// pwm timing counts
// ****************************************
`define PWM_LAST_SLOT      4'hf
`define MASTER_LAST_SUB    4'he
`define MASTER_OFF         4'h0
`define MASTER_FULL        4'hf
`define CODE_STATIC        4'hf
`define NUM_OUTPUTS        17
`define GROUP_SIZE         8

`endif

// file: design/led_pwm_pkg.sv
package led_pwm_pkg;
	typedef logic [3:0] level_type;
	typedef logic [7:0] byte_type;
	typedef enum logic {
		OSC_STOPPED,
		OSC_RUNNING
	} osc_state_type;
endpackage

// file: design/pwm_timing_if.sv
interface pwm_timing_if;
	logic [3:0] slot;
	logic [3:0] sub;
	logic [3:0] master;
	logic       run;
	logic       boundary;
	logic       blink_en;
	logic       blink_phase;
	modport src  (output slot, sub, master, run, boundary, blink_en, blink_phase);
	modport sink (input  slot, sub, master, run, boundary, blink_en, blink_phase);
endinterface

// file: design/led_slice.sv
`include "led_pwm_defs.svh"

module led_slice (
	input  wire logic                  i_clk,   // core clock
	input  wire logic                  i_rst,   // sync reset, active high
	pwm_timing_if.sink                 tm,      // shared pwm timing
	input  wire led_pwm_pkg::level_type i_code, // intensity code
	input  wire logic                  i_ph0,   // blink phase 0 bit
	input  wire logic                  i_ph1,   // blink phase 1 bit
	output logic                       o_drive  // high: pull pin low
);
	import led_pwm_pkg::*;

	logic ph_q;
	logic ph_d;
	logic drive_d;

	// ****************************************
	// phase bit, swapped only between pwm cycles
	// ****************************************
	always_comb begin
		ph_d = tm.blink_en ? (tm.blink_phase ? i_ph1 : i_ph0) : i_ph0;
	end

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			ph_q <= 1'b0;
		end else if (tm.boundary || !tm.run) begin
			ph_q <= ph_d;
		end
	end

	// ****************************************
	// drive decision
	// ****************************************
	always_comb begin
		drive_d = 1'b0;
		if (!tm.run) begin
			drive_d = 1'b0;
		end else if (i_code == `CODE_STATIC) begin
			drive_d = !ph_q;
		end else if (tm.sub < tm.master) begin
			// clear bit: low for code+1 slots; set bit: the remaining slots
			drive_d = ph_q ? (tm.slot > i_code) : (tm.slot <= i_code);
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			o_drive <= 1'b0;
		end else begin
			o_drive <= drive_d;
		end
	end

	// ****************************************
	// checks
	// ****************************************
	sequence s_low_window;
		tm.run && i_code != `CODE_STATIC && !ph_q && tm.slot <= i_code;
	endsequence

	property p_code_f_static;
		@(posedge i_clk) disable iff (i_rst)
		tm.run && i_code == `CODE_STATIC && !ph_q |=> o_drive;
	endproperty
	a_code_f_static: assert property (p_code_f_static) else $error("static low missing");

	property p_code_f_release;
		@(posedge i_clk) disable iff (i_rst)
		i_code == `CODE_STATIC && ph_q |=> !o_drive;
	endproperty
	a_code_f_release: assert property (p_code_f_release) else $error("static release missing");

	property p_low_window;
		@(posedge i_clk) disable iff (i_rst)
		s_low_window and (tm.sub < tm.master) |=> o_drive;
	endproperty
	a_low_window: assert property (p_low_window) else $error("low time not driven");

	property p_high_window;
		@(posedge i_clk) disable iff (i_rst)
		tm.run && i_code != `CODE_STATIC && !ph_q && tm.slot > i_code |=> !o_drive;
	endproperty
	a_high_window: assert property (p_high_window) else $error("high time driven");

	property p_swapped;
		@(posedge i_clk) disable iff (i_rst)
		ph_q && i_code != `CODE_STATIC && tm.slot <= i_code |=> !o_drive;
	endproperty
	a_swapped: assert property (p_swapped) else $error("swapped duty wrong");

	property p_full_master;
		@(posedge i_clk) disable iff (i_rst)
		s_low_window and (tm.master == `MASTER_FULL) |=> o_drive;
	endproperty
	a_full_master: assert property (p_full_master) else $error("full master gated");

	property p_phase_hold;
		@(posedge i_clk) disable iff (i_rst)
		tm.run && !tm.boundary |=> ph_q == $past(ph_q);
	endproperty
	a_phase_hold: assert property (p_phase_hold) else $error("phase changed mid cycle");
endmodule

// file: test/reg_host.sv
module reg_host (
	input  wire logic                  i_clk,    // core clock
	output logic                       o_strobe, // transfer request
	output logic                       o_rnw,    // 1 read, 0 write
	output led_pwm_pkg::byte_type      o_addr,   // register address
	output led_pwm_pkg::byte_type      o_wdata,  // write data
	input  wire led_pwm_pkg::byte_type i_rdata,  // read data
	input  wire logic                  i_rvalid  // read answer
);
	timeunit 1ns;
	timeprecision 100ps;
	import led_pwm_pkg::*;

	initial begin
		o_strobe = 1'b0;
		o_rnw = 1'b1;
		o_addr = 8'h00;
		o_wdata = 8'h00;
	end

	// after the taking edge the lines show the inverse, so stale values never pass
	task automatic xfer(input logic rnw, input byte_type addr, input byte_type wd,
			output byte_type rd);
		int n;
		@(posedge i_clk);
		#1;
		o_strobe = 1'b1;
		o_rnw = rnw;
		o_addr = addr;
		o_wdata = wd;
		@(posedge i_clk);
		#1;
		o_strobe = 1'b0;
		o_rnw = ~rnw;
		o_addr = ~addr;
		o_wdata = ~wd;
		n = 0;
		while (rnw && i_rvalid !== 1'b1 && n < 4) begin
			@(posedge i_clk);
			#1;
			n++;
		end
		// a read that never saw its answer hands back unknowns so the compare trips
		rd = !rnw ? 8'h00 : (i_rvalid === 1'b1) ? i_rdata : 8'hxx;
	endtask
endmodule

// file: test/test_led_pwm_intensity.sv
module test_led_pwm_intensity;
	timeunit 1ns;
	timeprecision 100ps;
	import led_pwm_pkg::*;

	logic                 i_clk = 1'b0;
	logic                 i_rst = 1'b1;
	logic                 strobe, rnw, rvalid, osc, ben, bph, gen;
	byte_type             addr, wdata, rdata, rd;
	level_type            gcode;
	level_type [15:0]     codes;
	logic [16:0]          ph0v, ph1v, led_o, oe;
	int                   err_count = 0;
	int                   compares = 0;

	always #2.5 i_clk = ~i_clk;

	reg_host host (.i_clk(i_clk), .o_strobe(strobe), .o_rnw(rnw), .o_addr(addr),
		.o_wdata(wdata), .i_rdata(rdata), .i_rvalid(rvalid));

	led_pwm_intensity dut (.i_clk(i_clk), .i_rst(i_rst), .i_reg_strobe(strobe),
		.i_reg_rnw(rnw), .i_reg_addr(addr), .i_reg_wdata(wdata), .o_reg_rdata(rdata),
		.o_reg_rvalid(rvalid), .i_blink_en(ben), .i_blink_phase(bph), .i_global_en(gen),
		.i_global_code(gcode), .i_out_codes(codes), .i_ph0_low_group(ph0v[7:0]),
		.i_ph0_high_group(ph0v[15:8]), .i_ph1_low_group(ph1v[7:0]),
		.i_ph1_high_group(ph1v[15:8]), .i_ph0_seventeenth(ph0v[16]),
		.i_ph1_seventeenth(ph1v[16]), .o_led_o(led_o), .o_led_oe(oe),
		.o_osc_running(osc));

	// ****************************************
	// compares and verdict
	// ****************************************
	task automatic check8(input byte_type got, input byte_type exp);
		compares++;
		if (got !== exp) begin
			err_count++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic check_cnt(input int got, input int exp);
		compares++;
		if (got != exp) begin
			err_count++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic final_report;
		$display("errors %0d compares %0d", err_count, compares);
		if (err_count == 0 && compares > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	// lit clocks per 240-clock pwm cycle
	function automatic int lit(input int c, input logic p, input int m);
		if (m == 0)
			return 0;
		if (c == 15)
			return p ? 0 : 240;
		return (p ? 15 - c : c + 1) * m;
	endfunction

	// any 240-clock window of a steady setting holds exactly one pwm cycle
	task automatic run(input byte_type r, input logic be, input logic bp);
		int cnt[17];
		int c;
		logic p;
		ben = be;
		bph = bp;
		host.xfer(1'b0, 8'h0e, r, rd);
		repeat (480) @(posedge i_clk);
		cnt = '{default: 0};
		repeat (240) begin
			@(posedge i_clk);
			#1;
			for (int i = 0; i < 17; i++)
				if (oe[i] === 1'b1)
					cnt[i]++;
		end
		for (int i = 0; i < 17; i++) begin
			c = (i == 16) ? int'(r[3:0]) : (gen ? int'(gcode) : int'(codes[i]));
			p = (be && bp) ? ph1v[i] : ph0v[i];
			check_cnt(cnt[i], lit(c, p, int'(r[7:4])));
		end
		check8({7'h00, osc}, {7'h00, r[7:4] != 4'h0});
		check8(led_o[7:0] | led_o[15:8] | {7'h00, led_o[16]}, 8'h00);
	endtask

	// ****************************************
	// tests
	// ****************************************
	initial begin
		ben = 1'b0;
		bph = 1'b0;
		gen = 1'b0;
		gcode = 4'h0;
		ph0v = '0;
		ph1v = '0;
		for (int i = 0; i < 16; i++)
			codes[i] = level_type'(i);
		repeat (5) @(posedge i_clk);
		#1;
		i_rst = 1'b0;
		host.xfer(1'b1, 8'h0e, 8'h00, rd);
		check8(rd, 8'h00);
		host.xfer(1'b0, 8'h0e, 8'h5a, rd);
		host.xfer(1'b0, 8'h0f, 8'ha5, rd);
		host.xfer(1'b1, 8'h0e, 8'h00, rd);
		check8(rd, 8'h5a);
		host.xfer(1'b1, 8'h0f, 8'h00, rd);
		check8(rd, 8'h00);
		run(8'hf0, 1'b0, 1'b0);
		ph0v = '1;
		run(8'hff, 1'b0, 1'b0);
		ph0v = '0;
		ph1v = '1;
		run(8'hd3, 1'b1, 1'b0);
		run(8'hd3, 1'b1, 1'b1);
		ph0v = '1;
		ph1v = '0;
		run(8'h1e, 1'b1, 1'b1);
		ph0v = 17'h100ff;
		run(8'h7e, 1'b0, 1'b0);
		gen = 1'b1;
		gcode = 4'h3;
		run(8'h2f, 1'b0, 1'b0);
		run(8'h05, 1'b0, 1'b0);
		final_report;
	end

	initial begin
		#100us;
		err_count++;
		final_report;
	end
endmodule
